// file: verilog/acc_pkg.sv
// Constants for the converter clock and control block.
// Assumes one 200 MHz system clock from which all timing is derived.
package acc_pkg;

  // Clock rates, in Hz
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FAST_OSC_HZ = 20_000_000;
  localparam int unsigned FP_BASE_HZ = 4_000_000;
  localparam int unsigned LP_BASE_HZ = 125_000;
  localparam int unsigned FP_MOD_ZERO_HZ = 2_000_000;

  // Derived cycle counts and counter widths
  localparam int unsigned OSC_DIV = CLK_HZ / FAST_OSC_HZ;
  localparam int unsigned FP_TICKS = FAST_OSC_HZ / FP_BASE_HZ;
  localparam int unsigned LP_TICKS = FAST_OSC_HZ / LP_BASE_HZ;
  localparam int unsigned SLOT_W = 8;
  localparam int unsigned OSC_W = 4;

  // Register offsets and field layout
  localparam logic [7:0] FP_DIV_LO_OFS = 8'hB2;
  localparam logic [7:0] FP_CLK_CFG_OFS = 8'hB3;
  localparam int unsigned DIV_W = 10;
  localparam int unsigned DIV_HI_LSB = 0;
  localparam int unsigned DIV_HI_MSB = 1;
  localparam int unsigned CHOP_PHASE_LSB = 3;
  localparam int unsigned CHOP_PHASE_MSB = 5;
  localparam int unsigned MOD_PHASE_LSB = 6;
  localparam int unsigned MOD_PHASE_MSB = 7;
  localparam logic [2:0] CHOP_PHASE_MAX = 3'h4;

  // Reset values
  localparam logic [7:0] FP_DIV_LO_RST = 8'h08;
  localparam logic [7:0] FP_CLK_CFG_RST = 8'h92;

  // Data path
  localparam int unsigned RESULT_W = 24;
  localparam int unsigned CHOP_CNT_W = 5;

  typedef enum logic [0:0] {
    ACC_PS_FULL = 1'b0,
    ACC_PS_LOW = 1'b1
  } acc_pwr_t;

  typedef enum logic [1:0] {
    ACC_VT_VOLT = 2'b00,
    ACC_VT_TEMP_INT = 2'b01,
    ACC_VT_TEMP_EXT = 2'b10
  } acc_vt_src_t;

endpackage : acc_pkg

// file: verilog/acc_clock_control.sv
// Converter clock generation and conversion flagging for two channels.
// Assumes configuration bytes come from the register file, synchronous.
//
// What this block does
// - Base clock runs at 4 MHz in full power and 125 kHz in low power.
// - Full-power modulator clock is base over twice the divider value.
// - In full power a zero divider gives a 2 MHz modulator clock.
// - Chop clock is modulator clock over two to the power (select+1).
// - One modulator clock and one chop clock reach both channels.
// - Modulator base lags the logic base by 1 to 4 fast cycles in full power, and by 0 in low power.
// - Chop base lags the logic base by 0 to 4 fast cycles.
// - Both converters run in step on shared clocks.
// - Current channel measures current only; second one is selectable.
// - Each finished conversion raises a data-ready pulse.
// - Results are stored for host readout.
// - Divider is ten bits, low byte at offset B2.
// - Chop phase sits in bits 5..3 and takes 0 to 4.
// - Modulator phase sits in bits 7..6.
module acc_clock_control (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Configuration
  input wire logic [7:0] FP_DIV_LO_I,
  input wire logic [7:0] FP_CLK_CFG_I,
  input wire logic [1:0] CHOP_SEL_I,
  input wire acc_pkg::acc_pwr_t PWR_STATE_I,
  input wire acc_pkg::acc_vt_src_t VT_SRC_I,
  // Conversion results from the data path
  input wire logic [1:0] CONV_DONE_I,
  input wire logic [acc_pkg::RESULT_W-1:0] CUR_RESULT_I,
  input wire logic [acc_pkg::RESULT_W-1:0] VT_RESULT_I,
  // Converter clocks and source select
  output logic LOGIC_BASE_O,
  output logic [1:0] MOD_CLK_O,
  output logic [1:0] CHOP_CLK_O,
  output acc_pkg::acc_vt_src_t VT_SRC_O,
  // Results
  output logic [acc_pkg::RESULT_W-1:0] CUR_DATA_O,
  output logic [acc_pkg::RESULT_W-1:0] VT_DATA_O,
  output logic [1:0] DATA_READY_O
);
  import acc_pkg::*;

  // Field decode
  // ten bit divider
  wire logic [DIV_W-1:0] fp_div;
  assign fp_div = {FP_CLK_CFG_I[DIV_HI_MSB:DIV_HI_LSB], FP_DIV_LO_I};
  wire logic [1:0] mod_phase;
  assign mod_phase = FP_CLK_CFG_I[MOD_PHASE_MSB:MOD_PHASE_LSB];
  // chop phase, out-of-range values clamp to the top slot
  wire logic [2:0] chop_phase_raw;
  wire logic [2:0] chop_phase;
  assign chop_phase_raw = FP_CLK_CFG_I[CHOP_PHASE_MSB:CHOP_PHASE_LSB];
  assign chop_phase = (chop_phase_raw > CHOP_PHASE_MAX) ?
                      CHOP_PHASE_MAX : chop_phase_raw;

  // Configuration snapshot for change detection
  localparam int unsigned SNAP_W = DIV_W + 2 + 3 + 2 + 1;
  logic [SNAP_W-1:0] snap_r;
  wire logic [SNAP_W-1:0] snap_nxt;
  wire logic cfg_change;
  // Raw phase field, so a write of 5 after 4 still restarts the clocks
  assign snap_nxt = {fp_div, mod_phase, chop_phase_raw, CHOP_SEL_I,
                     PWR_STATE_I};
  assign cfg_change = (snap_nxt != snap_r);

  // Fast oscillator tick from the system clock
  logic [OSC_W-1:0] osc_cnt_r;
  wire logic [OSC_W-1:0] osc_cnt_nxt;
  wire logic osc_tick;
  assign osc_tick = (osc_cnt_r == OSC_W'(OSC_DIV - 1));
  assign osc_cnt_nxt = osc_tick ? '0 : osc_cnt_r + OSC_W'(1);

  // base period in fast ticks follows the power state
  logic [SLOT_W-1:0] slot_r;
  wire logic [SLOT_W-1:0] slot_last;
  wire logic [SLOT_W-1:0] slot_nxt;
  wire logic full_pwr;
  assign full_pwr = (PWR_STATE_I == ACC_PS_FULL);
  assign slot_last = full_pwr ? SLOT_W'(FP_TICKS - 1) :
                     SLOT_W'(LP_TICKS - 1);
  assign slot_nxt = (slot_r >= slot_last) ? '0 : slot_r + SLOT_W'(1);

  // modulator base slot is phase plus one in full power, zero in low power
  wire logic [SLOT_W-1:0] mod_slot;
  assign mod_slot = full_pwr ? SLOT_W'({1'b0, mod_phase} + 3'h1) : '0;
  // chop base counts from the logic base, not the modulator base
  // relative delay is left to software programming
  wire logic [SLOT_W-1:0] chop_slot;
  assign chop_slot = full_pwr ? SLOT_W'(chop_phase) : '0;
  wire logic mod_evt;
  wire logic chop_evt;
  assign mod_evt = osc_tick && (slot_r == mod_slot);
  assign chop_evt = osc_tick && (slot_r == chop_slot);

  // toggle every divider value base edges
  // zero acts as one, giving half the base rate
  wire logic [DIV_W-1:0] div_last;
  assign div_last = (fp_div == '0) ? '0 : fp_div - DIV_W'(1);

  logic [DIV_W-1:0] mod_cnt_r;
  logic mod_clk_r;
  wire logic mod_wrap;
  wire logic [DIV_W-1:0] mod_cnt_nxt;
  assign mod_wrap = mod_evt && (mod_cnt_r >= div_last);
  assign mod_cnt_nxt = mod_wrap ? '0 :
                       (mod_evt ? mod_cnt_r + DIV_W'(1) : mod_cnt_r);

  // Chop path mirrors the divider on its own base so edges align
  logic [DIV_W-1:0] chop_cnt_r;
  logic [CHOP_CNT_W-1:0] chop_acc_r;
  logic chop_clk_r;
  wire logic chop_wrap;
  wire logic [DIV_W-1:0] chop_cnt_nxt;
  wire logic [CHOP_CNT_W-1:0] chop_acc_nxt;
  wire logic [2:0] chop_bit;
  assign chop_wrap = chop_evt && (chop_cnt_r >= div_last);
  assign chop_cnt_nxt = chop_wrap ? '0 :
                        (chop_evt ? chop_cnt_r + DIV_W'(1) : chop_cnt_r);
  assign chop_acc_nxt = chop_wrap ? chop_acc_r + CHOP_CNT_W'(1) :
                        chop_acc_r;
  // divide by two to the power select plus one
  assign chop_bit = {1'b0, CHOP_SEL_I} + 3'h1;

  // Logic base is high for the first part of its period
  wire logic base_nxt;
  assign base_nxt = (slot_nxt <= (slot_last >> 1));

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      snap_r <= '0;
      osc_cnt_r <= '0;
      slot_r <= '0;
      mod_cnt_r <= '0;
      mod_clk_r <= 1'b0;
      chop_cnt_r <= '0;
      chop_acc_r <= '0;
      chop_clk_r <= 1'b0;
      LOGIC_BASE_O <= 1'b0;
    end else if (CE_I) begin
      snap_r <= snap_nxt;
      // restart all counters, clocks held low
      if (cfg_change) begin
        osc_cnt_r <= '0;
        slot_r <= '0;
        mod_cnt_r <= '0;
        mod_clk_r <= 1'b0;
        chop_cnt_r <= '0;
        chop_acc_r <= '0;
        chop_clk_r <= 1'b0;
        LOGIC_BASE_O <= 1'b0;
      end else begin
        osc_cnt_r <= osc_cnt_nxt;
        if (osc_tick) begin
          slot_r <= slot_nxt;
          LOGIC_BASE_O <= base_nxt;
        end
        mod_cnt_r <= mod_cnt_nxt;
        if (mod_wrap) begin
          mod_clk_r <= ~mod_clk_r;
        end
        chop_cnt_r <= chop_cnt_nxt;
        chop_acc_r <= chop_acc_nxt;
        chop_clk_r <= chop_acc_nxt[chop_bit];
      end
    end
  end

  // same clocks fan out to both channels
  // shared clocks keep the converters in step
  assign MOD_CLK_O = {2{mod_clk_r}};
  assign CHOP_CLK_O = {2{chop_clk_r}};

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CUR_DATA_O <= '0;
      VT_DATA_O <= '0;
      DATA_READY_O <= '0;
      VT_SRC_O <= ACC_VT_VOLT;
    end else if (CE_I) begin
      DATA_READY_O <= CONV_DONE_I;
      // only the second channel has a source select
      VT_SRC_O <= VT_SRC_I;
      if (CONV_DONE_I[0]) begin
        CUR_DATA_O <= CUR_RESULT_I;
      end
      if (CONV_DONE_I[1]) begin
        VT_DATA_O <= VT_RESULT_I;
      end
    end
  end

endmodule : acc_clock_control

// file: dv/acc_clock_control_properties.sv
// Checker for the converter clock block, bound to its top ports.
// Assumes CLK_I domain only, NRST_I async active low.
module acc_props (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Configuration and conversion results
  input wire logic [7:0] FP_DIV_LO_I,
  input wire logic [7:0] FP_CLK_CFG_I,
  input wire logic [1:0] CHOP_SEL_I,
  input wire acc_pkg::acc_pwr_t PWR_STATE_I,
  input wire acc_pkg::acc_vt_src_t VT_SRC_I,
  input wire logic [1:0] CONV_DONE_I,
  input wire logic [acc_pkg::RESULT_W-1:0] CUR_RESULT_I,
  input wire logic [acc_pkg::RESULT_W-1:0] VT_RESULT_I,
  // Observed outputs
  input wire logic [1:0] MOD_CLK_O,
  input wire logic [1:0] CHOP_CLK_O,
  input wire acc_pkg::acc_vt_src_t VT_SRC_O,
  input wire logic [acc_pkg::RESULT_W-1:0] CUR_DATA_O,
  input wire logic [acc_pkg::RESULT_W-1:0] VT_DATA_O,
  input wire logic [1:0] DATA_READY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  a_mod_pair_eq: assert property (MOD_CLK_O[0] == MOD_CLK_O[1])
    else $error("modulator clock copies differ");
  a_chop_pair_eq: assert property (CHOP_CLK_O[0] == CHOP_CLK_O[1])
    else $error("chop clock copies differ");
  a_cur_ready: assert property (CE_I && CONV_DONE_I[0] |=> DATA_READY_O[0])
    else $error("current ready missing");
  a_vt_ready: assert property (CE_I && CONV_DONE_I[1] |=> DATA_READY_O[1])
    else $error("second channel ready missing");
  a_ready_cause: assert property (DATA_READY_O != 2'h0 |->
    $past(CONV_DONE_I) == DATA_READY_O) else $error("ready without done");
  a_cur_data: assert property (CE_I && CONV_DONE_I[0] |=>
    CUR_DATA_O == $past(CUR_RESULT_I)) else $error("current data wrong");
  a_vt_data: assert property (CE_I && CONV_DONE_I[1] |=>
    VT_DATA_O == $past(VT_RESULT_I)) else $error("second data wrong");
  a_vt_src_copy: assert property (CE_I |=> VT_SRC_O == $past(VT_SRC_I))
    else $error("source select not copied");
  a_cfg_restart: assert property ($changed({FP_DIV_LO_I, FP_CLK_CFG_I,
    CHOP_SEL_I, PWR_STATE_I}) |-> ##[0:2] (MOD_CLK_O == 2'h0 &&
    CHOP_CLK_O == 2'h0)) else $error("no restart on setting change");
endmodule : acc_props

bind acc_clock_control acc_props u_props (.CLK_I, .NRST_I, .CE_I,
  .FP_DIV_LO_I, .FP_CLK_CFG_I, .CHOP_SEL_I, .PWR_STATE_I, .VT_SRC_I,
  .CONV_DONE_I, .CUR_RESULT_I, .VT_RESULT_I, .MOD_CLK_O, .CHOP_CLK_O,
  .VT_SRC_O, .CUR_DATA_O, .VT_DATA_O, .DATA_READY_O);

// file: dv/acc_mod_model.sv
// Model of the two modulators: one result per four modulator rises.
// Assumes the modulator clock is a level sampled on clk_i.
module acc_mod_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] mod_clk_i,
  output logic [1:0] done_o,
  output logic [acc_pkg::RESULT_W-1:0] cur_o,
  output logic [acc_pkg::RESULT_W-1:0] vt_o
);
  logic m_r;
  logic [1:0] n_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_r <= 1'b0;
      n_r <= 2'h0;
      cur_o <= '0;
      done_o <= 2'h0;
    end else begin
      m_r <= mod_clk_i[0];
      done_o <= 2'h0;
      if (mod_clk_i[0] && !m_r) begin
        n_r <= n_r + 2'h1;
        if (n_r == 2'h3) begin
          done_o <= 2'h3;
          cur_o <= cur_o + 1'b1;
        end
      end
    end
  end
  assign vt_o = ~cur_o;
endmodule : acc_mod_model

// file: dv/adc_clock_and_control_test.sv
// Testbench: clock periods, phases, ready pulses and reset.
// Assumes 200 MHz clock; CE_I held high.
module adc_clock_and_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;
  logic clk = 0, nrst = 0, lbase;
  logic [7:0] div_lo = 0, cfg = 0;
  logic [1:0] sel = 0, done, mclk, cclk, rdy;
  acc_pwr_t pwr = ACC_PS_FULL;
  acc_vt_src_t vt = ACC_VT_VOLT, vto;
  logic [RESULT_W-1:0] cur, vres, cd, vd;
  int n_mismatch = 0, checked = 0, cyc = 0;
  // pwr, divider, select, mod phase, chop phase, mod and chop periods
  int rows[5][7] = '{'{0, 0, 0, 0, 0, 100, 200}, '{0, 1, 1, 1, 2, 100, 400},
    '{0, 3, 2, 2, 4, 300, 2400}, '{0, 2, 3, 3, 0, 200, 3200},
    '{1, 1, 0, 0, 0, 3200, 6400}};
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  acc_clock_control u_dut (.CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1),
    .FP_DIV_LO_I(div_lo), .FP_CLK_CFG_I(cfg), .CHOP_SEL_I(sel),
    .PWR_STATE_I(pwr), .VT_SRC_I(vt), .CONV_DONE_I(done),
    .CUR_RESULT_I(cur), .VT_RESULT_I(vres), .LOGIC_BASE_O(lbase),
    .MOD_CLK_O(mclk), .CHOP_CLK_O(cclk), .VT_SRC_O(vto),
    .CUR_DATA_O(cd), .VT_DATA_O(vd), .DATA_READY_O(rdy));
  acc_mod_model u_mod (.clk_i(clk), .nrst_i(nrst), .mod_clk_i(mclk),
    .done_o(done), .cur_o(cur), .vt_o(vres));
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  function automatic logic pick(input int k);
    return k == 0 ? mclk[0] : k == 1 ? cclk[0] : k == 2 ? done[0] : lbase;
  endfunction : pick
  // Bounded wait for a rising level of the picked signal
  task automatic rise(input int k, output int t);
    logic p;
    int i;
    p = pick(k);
    for (i = 0; i < 20000; i++) begin
      @(posedge clk);
      #1;
      if (pick(k) === 1'b1 && p === 1'b0) break;
      p = pick(k);
    end
    if (i == 20000) begin
      chk(1'b0, "timeout");
      final_report();
    end
    t = cyc;
  endtask : rise
  task automatic setc(input int p, d, s, mp, cp);
    @(posedge clk);
    #1;
    pwr = acc_pwr_t'(p);
    div_lo = 8'(d);
    cfg = {2'(mp), 3'(cp), 1'b0, 2'(d >> 8)};
    sel = 2'(s);
  endtask : setc
  initial begin
    int t0, t1, t2, d0;
    repeat (12) @(posedge clk);
    #1;
    chk({mclk, cclk, rdy} === 6'h00, "outputs busy in reset");
    nrst = 1;
    foreach (rows[i]) begin
      setc(rows[i][0], rows[i][1], rows[i][2], rows[i][3], rows[i][4]);
      rise(0, t1);
      rise(0, t2);
      chk(t2 - t1 == rows[i][5], "mod period");
      rise(1, t1);
      rise(1, t2);
      chk(t2 - t1 == rows[i][6], "chop period");
      $display("row %0d done", i);
    end
    for (int p = 0; p < 4; p++) begin
      setc(0, 1, 0, p, p);
      t0 = cyc;
      rise(0, t1);
      if (p == 0) d0 = t1 - t0;
      chk((t1 - t0 - d0 - 10 * p) % 50 == 0, "mod phase");
    end
    for (int c = 0; c < 6; c++) begin
      setc(0, 1, 0, 0, c);
      t0 = cyc;
      rise(1, t1);
      if (c == 0) d0 = t1 - t0;
      chk((t1 - t0 - d0 - 10 * (c > 4 ? 4 : c)) % 50 == 0, "chop phase");
    end
    rise(3, t1);
    rise(3, t2);
    chk(t2 - t1 == 50, "base period");
    $display("phase test done");
    for (int v = 0; v < 3; v++) begin
      vt = acc_vt_src_t'(v);
      rise(2, t1);
      t2 = int'(cur);
      @(posedge clk);
      #1;
      chk(rdy === 2'h3 && cd === cur && vd === ~cur && vto === vt, "ready");
    end
    $display("ready test done");
    nrst = 0;
    #1;
    chk({mclk, cclk, rdy} === 6'h00, "outputs busy in reset");
    setc(0, 1, 0, 0, 0);
    nrst = 1;
    rise(0, t1);
    rise(0, t2);
    chk(t2 - t1 == 100, "mod period after reset");
    $display("reset test done");
    final_report();
  end
endmodule : adc_clock_and_control_test
